// *** shared/mdps_pkg.sv ***
// package: types and constants for the motor drive protection sequencer
package mdps_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int ILIM_DELAY_NS = 3000;
	localparam int ILIM_DELAY_CYC = (ILIM_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFRESH_DIV = 5;
	localparam int PWM_PERIOD_CYC = 2500;
	localparam int REFRESH_CYC = PWM_PERIOD_CYC / REFRESH_DIV;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic VCC_LOCK_RST = 1'b1;
	localparam logic [2:0] BS_LOCK_RST = 3'h7;

	// ****************************************
	// speed-command regions
	// ****************************************
	typedef enum logic [1:0] {
		MDPS_REG_OFF = 2'b00,
		MDPS_REG_CHARGE = 2'b01,
		MDPS_REG_NOCHARGE = 2'b10
	} mdps_region_t;

	// ****************************************
	// over-current recovery states
	// ****************************************
	typedef enum logic [1:0] {
		MDPS_OC_IDLE = 2'b00,
		MDPS_OC_TRIP = 2'b01,
		MDPS_OC_REFRESH = 2'b10
	} mdps_oc_state_t;

	// comparator flags from the analog front end, all asynchronous
	typedef struct packed {
		logic ilim;
		logic ocp;
		logic vcc_uv;
		logic vcc_ok;
		logic therm_hot;
		logic therm_cool;
		logic refresh_on;
		logic refresh_off;
		logic speed_above_off;
		logic speed_above_55;
	} mdps_flags_t;

	// gate commands: bit i of each side belongs to phase i
	typedef struct packed {
		logic [2:0] hs;
		logic [2:0] ls;
	} mdps_gates_t;

	localparam mdps_gates_t MDPS_GATES_OFF = '{hs: 3'h0, ls: 3'h0};
endpackage

// *** hdl/mdps_sync.sv ***
// two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/10ps
module mdps_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	initial
	begin
		if (WIDTH < 1)
			$error("mdps_sync: WIDTH must be at least 1");
	end

	always_comb
	begin
		meta_d = meta_q;
		sync_d = sync_q;
		if (clk_en)
		begin
			meta_d = async_in;
			sync_d = meta_q;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule

// *** hdl/mdps_sequencer.sv ***
// protection and gate-gating sequencer of a three-phase brushless driver
`timescale 1ns/10ps
module mdps_sequencer
	import mdps_pkg::*;
#(
	parameter int ILIM_DELAY = ILIM_DELAY_CYC,
	parameter int REFRESH_LEN = REFRESH_CYC
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire mdps_pkg::mdps_flags_t flags_async,
	input wire logic [2:0] bs_uv_async,
	input wire logic [2:0] bs_ok_async,
	input wire logic [2:0] hall_pos,
	input wire logic pwm_on,
	input wire mdps_pkg::mdps_gates_t gate_cmd,
	output mdps_pkg::mdps_gates_t gate_out,
	output logic ilim_active,
	output logic ocp_active,
	output logic vcc_lockout,
	output logic therm_lockout,
	output logic [2:0] bs_lockout
);
	import mdps_pkg::*;

	initial
	begin
		// both counters are 16 bits wide; longer spans need wider counters
		if (ILIM_DELAY < 1 || ILIM_DELAY > 65535)
			$error("mdps_sequencer: ILIM_DELAY out of range");
		if (REFRESH_LEN < 1 || REFRESH_LEN > 65535)
			$error("mdps_sequencer: REFRESH_LEN out of range");
	end

	// ****************************************
	// input synchronisers
	// ****************************************
	localparam int NSYNC = $bits(mdps_flags_t) + 6;
	logic [NSYNC-1:0] sync_vec;
	mdps_flags_t fl;
	logic [2:0] bs_uv;
	logic [2:0] bs_ok;

	// comparator levels are asynchronous; only the second flop is ever read
	mdps_sync #(.WIDTH(NSYNC)) u_sync (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		.async_in({flags_async, bs_uv_async, bs_ok_async}),
		.sync_out(sync_vec)
	);
	assign fl = mdps_flags_t'(sync_vec[NSYNC-1:6]);
	assign bs_uv = sync_vec[5:3];
	assign bs_ok = sync_vec[2:0];

	// ****************************************
	// edge detection of same-domain inputs
	// ****************************************
	logic pwm_q;
	logic pwm_d;
	logic [2:0] hall_q;
	logic [2:0] hall_d;
	logic pwm_rise;
	logic pwm_fall;
	logic hall_edge;

	assign pwm_rise = pwm_on & ~pwm_q;
	assign pwm_fall = ~pwm_on & pwm_q;
	assign hall_edge = hall_pos != hall_q;

	// ****************************************
	// helpers
	// ****************************************
	// one lockout latch: a trip in the same cycle as a release keeps the lock
	function automatic logic f_lock_next(
		input logic lock_q,
		input logic trip,
		input logic clear
	);
		if (trip)
			return 1'b1;
		if (clear)
			return 1'b0;
		return lock_q;
	endfunction

	// ****************************************
	// protection latches
	// ****************************************
	logic ilim_q;
	logic ilim_d;
	logic [15:0] ilim_cnt_q;
	logic [15:0] ilim_cnt_d;
	logic vcc_q;
	logic vcc_d;
	logic therm_q;
	logic therm_d;
	logic [2:0] bs_q;
	logic [2:0] bs_d;
	mdps_oc_state_t oc_q;
	mdps_oc_state_t oc_d;

	always_comb
	begin
		ilim_d = ilim_q;
		ilim_cnt_d = ilim_cnt_q;
		vcc_d = vcc_q;
		therm_d = therm_q;
		bs_d = bs_q;
		oc_d = oc_q;
		if (clk_en)
		begin
			// delay counts only while the shunt stays above the limit level
			// a released limit times a fresh delay if the shunt is still high
			if (!fl.ilim || pwm_rise)
				ilim_cnt_d = 16'h0000;
			else if (ilim_cnt_q < 16'(ILIM_DELAY))
				ilim_cnt_d = ilim_cnt_q + 16'h0001;
			// a trip in the same cycle as the on edge wins over the release
			if (fl.ilim && ilim_cnt_q == 16'(ILIM_DELAY - 1))
				ilim_d = 1'b1;
			else if (pwm_rise)
				ilim_d = 1'b0;
			vcc_d = f_lock_next(vcc_q, fl.vcc_uv, fl.vcc_ok);
			therm_d = f_lock_next(therm_q, fl.therm_hot, fl.therm_cool);
			for (int i = 0; i < 3; i++)
				bs_d[i] = f_lock_next(bs_q[i], bs_uv[i], bs_ok[i]);
			// recovery pace comes from the timing-node comparators only
			case (oc_q)
				MDPS_OC_IDLE:
				begin
					if (fl.ocp)
						oc_d = MDPS_OC_TRIP;
				end
				MDPS_OC_TRIP:
				begin
					if (fl.refresh_on && !fl.ocp)
						oc_d = MDPS_OC_REFRESH;
				end
				MDPS_OC_REFRESH:
				begin
					if (fl.ocp)
						oc_d = MDPS_OC_TRIP;
					else if (fl.refresh_off)
						oc_d = MDPS_OC_IDLE;
				end
				default:
				begin
					oc_d = MDPS_OC_TRIP;
				end
			endcase
		end
	end

	// ****************************************
	// high-side enable and refresh pulse
	// ****************************************
	logic [2:0] hs_en_q;
	logic [2:0] hs_en_d;
	logic [15:0] rf_cnt_q;
	logic [15:0] rf_cnt_d;
	mdps_region_t region;

	always_comb
	begin
		// regions follow the synchronised comparators and lag the pin by two cycles
		if (!fl.speed_above_off)
			region = MDPS_REG_OFF;
		else if (fl.speed_above_55)
			region = MDPS_REG_NOCHARGE;
		else
			region = MDPS_REG_CHARGE;
	end

	always_comb
	begin
		hs_en_d = hs_en_q;
		rf_cnt_d = rf_cnt_q;
		pwm_d = pwm_q;
		hall_d = hall_q;
		if (clk_en)
		begin
			pwm_d = pwm_on;
			hall_d = hall_pos;
			// the level-shift pulse only exists on an edge; a blocked side waits
			if (hall_edge || pwm_rise)
				hs_en_d = 3'h7;
			hs_en_d = hs_en_d & ~bs_q & ~bs_uv;
			// a forced-off high side waits for a fresh edge before turning on again
			if (vcc_q || therm_q || oc_q != MDPS_OC_IDLE)
				hs_en_d = 3'h0;
			// a pwm fall in the charge region starts the window, and the next pwm on phase cuts it short
			if (pwm_fall && region == MDPS_REG_CHARGE)
				rf_cnt_d = 16'(REFRESH_LEN);
			else if (pwm_on || region != MDPS_REG_CHARGE)
				rf_cnt_d = 16'h0000;
			else if (rf_cnt_q != 16'h0000)
				rf_cnt_d = rf_cnt_q - 16'h0001;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			ilim_q <= 1'b0;
			ilim_cnt_q <= 16'h0000;
			vcc_q <= VCC_LOCK_RST;
			therm_q <= 1'b0;
			bs_q <= BS_LOCK_RST;
			oc_q <= MDPS_OC_IDLE;
			hs_en_q <= 3'h0;
			rf_cnt_q <= 16'h0000;
			// edge detectors track their pins in reset, so release makes no false edge
			pwm_q <= pwm_on;
			hall_q <= hall_pos;
		end
		else
		begin
			ilim_q <= ilim_d;
			ilim_cnt_q <= ilim_cnt_d;
			vcc_q <= vcc_d;
			therm_q <= therm_d;
			bs_q <= bs_d;
			oc_q <= oc_d;
			hs_en_q <= hs_en_d;
			rf_cnt_q <= rf_cnt_d;
			pwm_q <= pwm_d;
			hall_q <= hall_d;
		end
	end

	// ****************************************
	// output gating
	// ****************************************
	mdps_gates_t gate_d;
	mdps_gates_t gate_q;
	logic all_off;

	// one registered stage costs a cycle but keeps the gate pins glitch-free
	assign all_off = vcc_q | therm_q | oc_q == MDPS_OC_TRIP;

	always_comb
	begin
		gate_d = gate_q;
		if (clk_en)
		begin
			// chopping is applied to the high side only
			gate_d.hs = gate_cmd.hs & hs_en_q & ~bs_q & {3{pwm_on}};
			if (ilim_q)
				gate_d.hs = 3'h0;
			gate_d.ls = gate_cmd.ls;
			if (rf_cnt_q != 16'h0000 && region == MDPS_REG_CHARGE)
				gate_d.ls = gate_d.ls | gate_cmd.hs;
			// over-current refresh wins over the pwm refresh and keeps the high side off
			if (oc_q == MDPS_OC_REFRESH)
			begin
				gate_d.hs = 3'h0;
				gate_d.ls = gate_cmd.hs;
			end
			if (region == MDPS_REG_OFF || all_off)
				gate_d = MDPS_GATES_OFF;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			gate_q <= MDPS_GATES_OFF;
		else
			gate_q <= gate_d;
	end

	// status outputs are the latches themselves and need no extra stage
	assign gate_out = gate_q;
	assign ilim_active = ilim_q;
	assign ocp_active = oc_q != MDPS_OC_IDLE;
	assign vcc_lockout = vcc_q;
	assign therm_lockout = therm_q;
	assign bs_lockout = bs_q;
endmodule

// *** tb/mdps_props.sv ***
// checker: gate masking relations at the sequencer ports
`timescale 1ns/10ps
module mdps_props
	import mdps_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire mdps_pkg::mdps_flags_t flags_async,
	input wire logic pwm_on,
	input wire mdps_pkg::mdps_gates_t gate_cmd,
	input wire mdps_pkg::mdps_gates_t gate_out,
	input wire logic ilim_active,
	input wire logic vcc_lockout,
	input wire logic therm_lockout,
	input wire logic [2:0] bs_lockout
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	supply_off_a: assert property (vcc_lockout && $past(vcc_lockout) |-> gate_out == 6'h00)
		else $error("gates on in supply lockout");
	therm_off_a: assert property (therm_lockout && $past(therm_lockout) |-> gate_out == 6'h00)
		else $error("gates on in thermal lockout");
	chop_high_a: assert property (gate_out.hs != 3'h0 |-> $past(pwm_on))
		else $error("high side on outside pwm on phase");
	cmd_mask_a: assert property ((gate_out.hs & ~$past(gate_cmd.hs)) == 3'h0)
		else $error("high side on without command");
	ocp_off_a: assert property (flags_async.ocp [*4] |=> gate_out == 6'h00)
		else $error("gates on after over-current");
	region_off_a: assert property (!flags_async.speed_above_off [*4] |=> gate_out == 6'h00)
		else $error("gates on in lowest region");
	boot_block_a: assert property ((gate_out.hs & bs_lockout & $past(bs_lockout)) == 3'h0)
		else $error("high side on in bootstrap lockout");
	limit_hold_a: assert property (ilim_active && $past(ilim_active) |-> gate_out.hs == 3'h0)
		else $error("high side on in current limit");
	cover property ($rose(ilim_active));
	cover property ($rose(therm_lockout));
	cover property (bs_lockout != 3'h0 ##1 bs_lockout == 3'h0);
endmodule

// *** tb/mdps_stage.sv ***
// partner: power stage whose shunt sees current while a high side conducts
`timescale 1ns/10ps
module mdps_stage
	import mdps_pkg::*;
(
	input wire mdps_pkg::mdps_gates_t gates,
	input wire logic overload,
	input wire logic short_load,
	output logic shunt_ilim,
	output logic shunt_ocp
);
	// the flags drop as soon as the switches open, as a real shunt would
	assign shunt_ilim = overload && gates.hs != 3'h0;
	assign shunt_ocp = short_load && gates.hs != 3'h0;
endmodule

// *** tb/motor_drive_protection_sequencer_bench.sv ***
// bench: self-checking scenarios for the protection sequencer
`timescale 1ns/10ps
module motor_drive_protection_sequencer_bench;
	import mdps_pkg::*;
	localparam int ILD = 4;
	localparam int REF = 8;
	logic core_clk, reset, clk_en, pwm_on, ovl, shrt, s_ilim, s_ocp, ilim_a, ocp_a, vcc_l, th_l;
	logic [2:0] bs_uv, bs_ok, hall_pos, bs_l;
	mdps_flags_t fl, fa;
	mdps_gates_t gc, go;
	int err_total, cmp_count;
	always_comb
	begin
		fa = fl;
		fa.ilim = s_ilim;
		fa.ocp = s_ocp;
	end
	mdps_sequencer #(.ILIM_DELAY(ILD), .REFRESH_LEN(REF)) i_mdps_sequencer (
		.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .flags_async(fa),
		.bs_uv_async(bs_uv), .bs_ok_async(bs_ok), .hall_pos(hall_pos), .pwm_on(pwm_on),
		.gate_cmd(gc), .gate_out(go), .ilim_active(ilim_a), .ocp_active(ocp_a),
		.vcc_lockout(vcc_l), .therm_lockout(th_l), .bs_lockout(bs_l));
	mdps_stage i_mdps_stage (.gates(go), .overload(ovl), .short_load(shrt),
		.shunt_ilim(s_ilim), .shunt_ocp(s_ocp));
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic pwm_edge();
		pwm_on = 1'b0;
		cyc(2);
		pwm_on = 1'b1;
		cyc(REF + 2);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic t_start();
		chk("reset lock", {bs_l, 2'h0, vcc_l}, 6'h39);
		fl.vcc_ok = 1'b1;
		bs_ok = 3'h7;
		cyc(4);
		chk("bs lock", {3'h0, bs_l}, 6'h00);
		pwm_edge();
		chk("drive", go, 6'h0A);
	endtask
	task automatic t_freeze();
		clk_en = 1'b0;
		fl.vcc_uv = 1'b1;
		fl.vcc_ok = 1'b0;
		cyc(6);
		chk("freeze", {vcc_l, go}, 8'h0A);
		clk_en = 1'b1;
		fl.vcc_uv = 1'b0;
		fl.vcc_ok = 1'b1;
		cyc(2);
		chk("thaw", {vcc_l, go}, 8'h0A);
	endtask
	task automatic t_supply();
		fl.vcc_uv = 1'b1;
		fl.vcc_ok = 1'b0;
		cyc(4);
		fl.vcc_uv = 1'b0;
		cyc(4);
		chk("supply hyst", {5'h0, vcc_l}, 6'h01);
		fl.vcc_ok = 1'b1;
		cyc(4);
		chk("supply back", go, 6'h02);
		hall_pos = 3'h1;
		cyc(2);
		chk("hall edge", go, 6'h0A);
		fl.therm_hot = 1'b1;
		fl.therm_cool = 1'b0;
		cyc(4);
		fl.therm_hot = 1'b0;
		cyc(4);
		chk("therm hyst", {5'h0, th_l}, 6'h01);
		fl.therm_cool = 1'b1;
		cyc(4);
		pwm_edge();
		chk("therm back", go, 6'h0A);
	endtask
	task automatic t_boot();
		bs_uv = 3'h1;
		bs_ok = 3'h6;
		cyc(4);
		bs_uv = 3'h0;
		cyc(4);
		chk("bs hyst", go, 6'h02);
		bs_ok = 3'h7;
		cyc(4);
		pwm_edge();
		chk("bs back", go, 6'h0A);
	endtask
	task automatic t_ocp();
		shrt = 1'b1;
		cyc(40);
		shrt = 1'b0;
		chk("ocp off", {ocp_a, go}, 8'h40);
		fl.refresh_on = 1'b1;
		cyc(4);
		chk("ocp refresh", {ocp_a, go}, 8'h41);
		fl.refresh_off = 1'b1;
		cyc(4);
		fl.refresh_on = 1'b0;
		fl.refresh_off = 1'b0;
		pwm_edge();
		chk("ocp back", {ocp_a, go}, 6'h0A);
	endtask
	task automatic t_ilim();
		ovl = 1'b1;
		cyc(ILD);
		chk("limit delay", go, 6'h0A);
		cyc(5);
		chk("limit off", {ilim_a, go}, 8'h42);
		ovl = 1'b0;
		pwm_edge();
		chk("limit back", go, 6'h0A);
	endtask
	task automatic t_refresh();
		pwm_on = 1'b0;
		cyc(3);
		chk("refresh on", go, 6'h03);
		cyc(REF - 2);
		chk("refresh len", go, 6'h03);
		cyc(1);
		chk("refresh end", go, 6'h02);
		fl.speed_above_55 = 1'b1;
		pwm_edge();
		pwm_on = 1'b0;
		cyc(3);
		chk("no charge", go, 6'h02);
		fl.speed_above_off = 1'b0;
		pwm_on = 1'b1;
		cyc(5);
		chk("all off", go, 6'h00);
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial
	begin
		#200000;
		err_total++;
		summarize();
	end
	initial
	begin
		err_total = 0;
		cmp_count = 0;
		reset = 1'b1;
		clk_en = 1'b1;
		pwm_on = 1'b1;
		ovl = 1'b0;
		shrt = 1'b0;
		fl = '0;
		fl.therm_cool = 1'b1;
		fl.speed_above_off = 1'b1;
		bs_uv = 3'h0;
		bs_ok = 3'h0;
		hall_pos = 3'h0;
		gc = '{hs: 3'h1, ls: 3'h2};
		cyc(20);
		reset = 1'b0;
		t_start();
		t_freeze();
		t_supply();
		t_boot();
		t_ocp();
		t_ilim();
		t_refresh();
		summarize();
	end
endmodule
bind mdps_sequencer mdps_props i_mdps_props (.core_clk(core_clk), .reset(reset),
	.flags_async(flags_async), .pwm_on(pwm_on), .gate_cmd(gate_cmd), .gate_out(gate_out),
	.ilim_active(ilim_active), .vcc_lockout(vcc_lockout), .therm_lockout(therm_lockout),
	.bs_lockout(bs_lockout));
